// *** rtl/process_supervisor_operators.sv ***
// supervisor, process and miscellaneous operator unit of the processor
// assumes stacks, arithmetic unit and memory answer in the same clock domain
// What this block does
// - coroutine exit saves field, restores parent, pops display
// - direct pass: level-one ref gets direct bit
// - indirect pass clears direct bit before push
// - resource and process operators need privileged mode
// - process create adds slice, level plus one
// - process remove drops slice, level minus one
// - literal pushes value and buffered reference
// - interrupt post uses value top channel, pops
// - fault scan: external mask enters supervisor
// - fault push number, data reference, clear pending
// - nothing pending unmasked means just continue
// - set system flag enters supervisor with number
// - value space needs data description, else fault
// - supervisor entry: privileged, sensing off, save level
// - entry updates five, purges, loads base, jumps
// - programmatic entry waits for arithmetic completion
// - return: normal mode, sensing on, process slice
// - variant register loads from value top, pops
// - attribute write takes arithmetic unit result
// - privileged mode skips fault and flag scans; illegal operators still raise faults
`timescale 1ns/1ps
`include "psv_defs.svh"
module process_supervisor_operators #(
  parameter int NFLT = 65,
  parameter int NFLG = 17,
  parameter logic [6:0] FLT_ILLEGAL = 7'h40,
  parameter logic [31:0] SUP_ENTRY = 32'h00000100,
  parameter logic [31:0] PROC_ENTRY = 32'h00000200
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_r,
  // operator issue
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [31:0] op_ref,
  input wire logic [1:0] op_len,
  input wire logic ref_is_l1,
  input wire logic desc_is_data,
  output logic op_done_r,
  // stack tops and arithmetic unit
  input wire logic [31:0] value_stack_top,
  input wire logic [15:0] cd_parent_ccf,
  input wire logic arith_done,
  input wire logic [31:0] arith_result,
  // fault and flag sources
  input wire logic [NFLT-1:0] fault_set,
  input wire logic [NFLG-1:0] flag_pin,
  // stack strobes
  output logic vs_push_r,
  output logic vs_alloc_r,
  output logic vs_pop_r,
  output logic ns_push_r,
  output logic [1:0] ns_tag_r,
  output logic [31:0] st_data_r,
  output logic rs_push_r,
  output logic [31:0] rs_data_r,
  output logic slice_new_r,
  output logic slice_del_r,
  output logic cd_pop_r,
  output logic ccf_wr_r,
  output logic [15:0] ccf_old_r,
  output logic [15:0] ccf_r,
  // side effects
  output logic irq_r,
  output logic [7:0] irq_chan_r,
  output logic fault_r,
  output logic handler_r,
  output logic [6:0] handler_num_r,
  output logic attr_wr_r,
  output logic [31:0] attr_val_r,
  output logic [31:0] avr_r,
  output logic [7:0] level_r,
  // supervisor sequence
  output logic priv_r,
  output logic sense_r,
  output logic upd_r,
  output logic [2:0] upd_idx_r,
  output logic purge_r,
  output logic load_base_r,
  output logic load_proc_r,
  output logic pcr_load_r,
  output logic [31:0] pcr_val_r
);

  // refuse widths the 96-bit scan cannot hold
  if (NFLT > 96 || NFLG > 96 || NFLT < 1 || NFLG < 1) begin : g_bad
    $error("fault or flag count out of range");
  end
  // lowest set bit: {found, index}
  function automatic logic [7:0] lowest(input logic [95:0] v);
    lowest = 8'h00;
    for (int i = 95; i >= 0; i--) begin
      if (v[i]) lowest = {1'b1, 7'(i)};
    end
  endfunction : lowest
  psv_pkg::state_e state_r; // sequencer state
  logic [95:0] pend_r; // pending faults
  logic [95:0] emask_r; // external fault mask
  logic [95:0] pmask_r; // process fault mask
  logic [NFLG-1:0] flg_s1_r; // flag synchroniser stage one
  logic [NFLG-1:0] flg_s2_r; // flag synchroniser stage two
  logic [2:0] cnt_r; // update step count
  logic entering_r; // sequence is an entry, not a return
  logic wait_attr_r; // waiting for attribute conversion
  logic [6:0] cause_r; // programmatic entry cause
  // operator decode
  wire psv_pkg::op_e op = psv_pkg::op_e'(op_code);
  wire op_go = op_valid && state_r == psv_pkg::S_IDLE;
  wire is_res = op == psv_pkg::OP_RES_DIRECT || op == psv_pkg::OP_RES_INDIRECT;
  wire is_proc = op == psv_pkg::OP_PROC_CREATE || op == psv_pkg::OP_PROC_REMOVE;
  wire bad_priv = !priv_r && (is_res || is_proc || op == psv_pkg::OP_SUP_RETURN);
  wire raise = op_go && (bad_priv || (is_res && !ref_is_l1)
    || (op == psv_pkg::OP_GET_VSPACE && !desc_is_data));
  wire ok_go = op_go && !raise;
  // scans; sensing is off in privileged mode
  wire [7:0] flt_hit = lowest(pend_r & (emask_r | pmask_r));
  wire [7:0] flg_hit = lowest({{(96-NFLG){1'b0}}, flg_s2_r});
  wire [6:0] flt_idx = flt_hit[6:0];
  wire flt_ext = emask_r[flt_idx];
  wire flt_go = ok_go && op == psv_pkg::OP_FAULT_CHECK && sense_r && flt_hit[7];
  wire flg_go = ok_go && op == psv_pkg::OP_FLAG_CHECK && sense_r && flg_hit[7];
  wire au_go = state_r == psv_pkg::S_WAIT_AU && arith_done;
  wire ent_go = (flt_go && flt_ext) || flg_go || (au_go && !wait_attr_r);
  wire [6:0] ent_num = flt_go ? flt_idx : (flg_go ? flg_hit[6:0] : cause_r);
  wire push_num = flt_go || ent_go;
  wire ret_go = ok_go && op == psv_pkg::OP_SUP_RETURN;
  wire seq_go = ent_go || ret_go;
  wire stay = ok_go && (op == psv_pkg::OP_SUP_CALL || op == psv_pkg::OP_SET_ATTR);
  // pending register: a new fault wins over the clear
  wire [95:0] clr_vec = flt_go ? (96'h1 << flt_idx) : 96'h0;
  wire [95:0] raise_vec = raise ? (96'h1 << FLT_ILLEGAL) : 96'h0;
  wire [95:0] pend_nxt = (pend_r & ~clr_vec) | {{(96-NFLT){1'b0}}, fault_set} | raise_vec;
  // literal length mask
  wire [31:0] lit_mask = op_len == 2'h0 ? 32'h0000000f : op_len == 2'h1 ? 32'h000000ff :
    op_len == 2'h2 ? 32'h0000ffff : 32'hffffffff;
  // register read selection
  wire [31:0] status_w = {29'h0, state_r != psv_pkg::S_IDLE, sense_r, priv_r};
  wire [31:0] rd_sel =
    reg_addr == `REG_STATUS ? status_w :
    reg_addr == `REG_EMASK0 ? emask_r[31:0] :
    reg_addr == `REG_EMASK0 + 8'h04 ? emask_r[63:32] :
    reg_addr == `REG_EMASK0 + 8'h08 ? emask_r[95:64] :
    reg_addr == `REG_PMASK0 ? pmask_r[31:0] :
    reg_addr == `REG_PMASK0 + 8'h04 ? pmask_r[63:32] :
    reg_addr == `REG_PMASK0 + 8'h08 ? pmask_r[95:64] :
    reg_addr == `REG_AVR ? avr_r :
    reg_addr == `REG_LEVEL ? {24'h0, level_r} :
    reg_addr == `REG_PEND0 ? pend_r[31:0] :
    reg_addr == `REG_PEND0 + 8'h04 ? pend_r[63:32] :
    reg_addr == `REG_PEND0 + 8'h08 ? pend_r[95:64] :
    reg_addr == `REG_CCF ? {16'h0, ccf_r} : 32'h0;
  // flag synchroniser, pending faults and register port
  always_ff @(posedge clk) begin
    flg_s1_r <= flag_pin;
    flg_s2_r <= flg_s1_r;
    if (sys_rst) begin
      pend_r <= 96'h0;
      emask_r <= 96'h0;
      pmask_r <= 96'h0;
      reg_rdata_r <= 32'h0;
    end else begin
      pend_r <= pend_nxt;
      reg_rdata_r <= reg_rd ? rd_sel : 32'h0;
      for (int w = 0; w < 3; w++) begin
        if (reg_wr && reg_addr == `REG_EMASK0 + 8'(4 * w)) emask_r[w*32 +: 32] <= reg_wdata;
        if (reg_wr && reg_addr == `REG_PMASK0 + 8'(4 * w)) pmask_r[w*32 +: 32] <= reg_wdata;
      end
    end
  end

  // stack strobes and operator side effects
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vs_push_r <= 1'b0;
      vs_alloc_r <= 1'b0;
      vs_pop_r <= 1'b0;
      ns_push_r <= 1'b0;
      ns_tag_r <= 2'h0;
      st_data_r <= 32'h0;
      rs_push_r <= 1'b0;
      rs_data_r <= 32'h0;
      slice_new_r <= 1'b0;
      slice_del_r <= 1'b0;
      cd_pop_r <= 1'b0;
      ccf_wr_r <= 1'b0;
      ccf_old_r <= `CCF_RST;
      ccf_r <= `CCF_RST;
      irq_r <= 1'b0;
      irq_chan_r <= 8'h0;
      fault_r <= 1'b0;
      handler_r <= 1'b0;
      handler_num_r <= 7'h0;
      attr_wr_r <= 1'b0;
      attr_val_r <= 32'h0;
      avr_r <= `AVR_RST;
      level_r <= `LEVEL_RST;
    end else begin
      // one-cycle strobes fall by default
      vs_push_r <= push_num;
      vs_alloc_r <= 1'b0;
      vs_pop_r <= 1'b0;
      ns_push_r <= push_num;
      rs_push_r <= 1'b0;
      slice_new_r <= 1'b0;
      slice_del_r <= 1'b0;
      cd_pop_r <= 1'b0;
      ccf_wr_r <= 1'b0;
      irq_r <= 1'b0;
      fault_r <= raise;
      handler_r <= 1'b0;
      attr_wr_r <= au_go && wait_attr_r;
      if (au_go && wait_attr_r) attr_val_r <= arith_result;
      if (push_num) begin
        // cause number with a data-typed buffered reference
        st_data_r <= {25'h0, ent_num};
        ns_tag_r <= `TAG_DATA;
      end
      if (ent_go) begin
        // save exited level in the supervisor resource stack
        rs_push_r <= 1'b1;
        rs_data_r <= {24'h0, level_r};
      end
      if (flt_go && !flt_ext) begin
        handler_r <= 1'b1;
        handler_num_r <= flt_idx;
      end
      if (ok_go) begin
        case (op)
          psv_pkg::OP_CO_EXIT: begin
            ccf_wr_r <= 1'b1;
            ccf_old_r <= ccf_r;
            ccf_r <= cd_parent_ccf;
            cd_pop_r <= 1'b1;
          end
          psv_pkg::OP_RES_DIRECT, psv_pkg::OP_RES_INDIRECT: begin
            rs_push_r <= 1'b1;
            rs_data_r <= {op == psv_pkg::OP_RES_DIRECT, op_ref[30:0]};
          end
          psv_pkg::OP_PROC_CREATE: begin
            slice_new_r <= 1'b1;
            level_r <= level_r + 8'h01;
          end
          psv_pkg::OP_PROC_REMOVE: begin
            slice_del_r <= 1'b1;
            level_r <= level_r - 8'h01;
          end
          psv_pkg::OP_LITERAL: begin
            vs_push_r <= 1'b1;
            ns_push_r <= 1'b1;
            st_data_r <= op_ref & lit_mask;
            ns_tag_r <= `TAG_BUF;
          end
          psv_pkg::OP_POST_IRQ: begin
            irq_r <= 1'b1;
            irq_chan_r <= value_stack_top[7:0];
            vs_pop_r <= 1'b1;
          end
          psv_pkg::OP_GET_VSPACE: begin
            vs_alloc_r <= 1'b1;
            ns_push_r <= 1'b1;
            st_data_r <= op_ref;
            ns_tag_r <= `TAG_BUF;
          end
          psv_pkg::OP_LOAD_AVR: begin
            avr_r <= value_stack_top;
            vs_pop_r <= 1'b1;
          end
          default: begin
            // scans and sequences handled elsewhere
          end
        endcase
      end
    end
  end

  // supervisor entry and return sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= psv_pkg::S_IDLE;
      priv_r <= 1'b0;
      sense_r <= 1'b1;
      upd_r <= 1'b0;
      upd_idx_r <= 3'h0;
      purge_r <= 1'b0;
      load_base_r <= 1'b0;
      load_proc_r <= 1'b0;
      pcr_load_r <= 1'b0;
      pcr_val_r <= 32'h0;
      cnt_r <= 3'h0;
      entering_r <= 1'b0;
      wait_attr_r <= 1'b0;
      cause_r <= 7'h0;
      op_done_r <= 1'b0;
    end else begin
      purge_r <= 1'b0;
      load_base_r <= 1'b0;
      load_proc_r <= 1'b0;
      pcr_load_r <= 1'b0;
      upd_r <= 1'b0;
      op_done_r <= (op_go && !seq_go && !stay) || (au_go && wait_attr_r);
      if (seq_go) begin
        // first of five resource slice updates
        priv_r <= ent_go;
        sense_r <= !ent_go;
        entering_r <= ent_go;
        upd_r <= 1'b1;
        upd_idx_r <= 3'h0;
        cnt_r <= 3'h0;
        state_r <= psv_pkg::S_UPD;
      end else begin
        case (state_r)
          psv_pkg::S_IDLE: begin
            if (stay) begin
              // programmatic entry or attribute conversion waits
              wait_attr_r <= op == psv_pkg::OP_SET_ATTR;
              cause_r <= op_ref[6:0];
              state_r <= psv_pkg::S_WAIT_AU;
            end
          end
          psv_pkg::S_WAIT_AU: begin
            if (arith_done) state_r <= psv_pkg::S_IDLE;
          end
          psv_pkg::S_UPD: begin
            if (cnt_r == `UPD_LAST) begin
              purge_r <= 1'b1;
              state_r <= psv_pkg::S_PURGE;
            end else begin
              upd_r <= 1'b1;
              upd_idx_r <= cnt_r + 3'h1;
              cnt_r <= cnt_r + 3'h1;
            end
          end
          psv_pkg::S_PURGE: begin
            // base slice on entry, level-selected slice on return
            load_base_r <= entering_r;
            load_proc_r <= !entering_r;
            pcr_load_r <= 1'b1;
            pcr_val_r <= entering_r ? SUP_ENTRY : PROC_ENTRY;
            op_done_r <= 1'b1;
            state_r <= psv_pkg::S_LOAD;
          end
          psv_pkg::S_LOAD: begin
            state_r <= psv_pkg::S_IDLE;
          end
          default: begin
            state_r <= psv_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence entry_steps;
    (priv_r && upd_r) [*5] ##1 purge_r ##1 (load_base_r && pcr_load_r);
  endsequence

  chk_priv_fault: assert property (op_go && bad_priv |=> fault_r && !rs_push_r)
    else $error("unprivileged operator did not fault");
  chk_exit_ccf: assert property (ok_go && op == psv_pkg::OP_CO_EXIT
    |=> cd_pop_r && ccf_wr_r && ccf_r == $past(cd_parent_ccf))
    else $error("coroutine exit wrong");
  chk_level_inc: assert property (ok_go && op == psv_pkg::OP_PROC_CREATE
    |=> slice_new_r && level_r == $past(level_r) + 8'h01)
    else $error("level not raised");
  chk_lit_push: assert property (ok_go && op == psv_pkg::OP_LITERAL
    |=> vs_push_r && ns_push_r && ns_tag_r == `TAG_BUF)
    else $error("literal not pushed");
  chk_entry_seq: assert property (ent_go |=> entry_steps)
    else $error("supervisor entry sequence wrong");
  chk_au_wait: assert property (state_r == psv_pkg::S_WAIT_AU && !arith_done
    |=> state_r == psv_pkg::S_WAIT_AU && !upd_r)
    else $error("entry started before arithmetic done");
  chk_fault_clear: assert property (flt_go && !fault_set[flt_idx]
    |=> !pend_r[$past(flt_idx)] && vs_push_r && ns_tag_r == `TAG_DATA)
    else $error("fault not cleared");
  chk_ret_mode: assert property (ret_go |=> !priv_r && sense_r ##6 load_proc_r)
    else $error("return sequence wrong");
  chk_avr_load: assert property (ok_go && op == psv_pkg::OP_LOAD_AVR
    |=> avr_r == $past(value_stack_top) && vs_pop_r)
    else $error("variant register not loaded");

endmodule : process_supervisor_operators

// *** rtl/psv_defs.svh ***
// register offsets, field positions and reset values of the supervisor operator block
// assumes a plain word-addressed register port with 8-bit byte addresses
`ifndef PSV_DEFS_SVH
`define PSV_DEFS_SVH
`define REG_STATUS 8'h00
`define REG_EMASK0 8'h04
`define REG_PMASK0 8'h10
`define REG_AVR 8'h1c
`define REG_LEVEL 8'h20
`define REG_PEND0 8'h24
`define REG_CCF 8'h30
`define ST_PRIV 0
`define ST_SENSE 1
`define ST_BUSY 2
`define TAG_BUF 2'h2
`define TAG_DATA 2'h3
`define RS_DIRECT 31
`define UPD_LAST 3'h4
`define AVR_RST 32'h00000000
`define CCF_RST 16'h0000
`define LEVEL_RST 8'h00
`endif

// *** rtl/psv_pkg.sv ***
// types shared by the supervisor operator block
// assumes nothing beyond a SystemVerilog compiler
package psv_pkg;
  // operator codes presented on op_code
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000,
    OP_CO_EXIT = 4'b0001,
    OP_RES_DIRECT = 4'b0010,
    OP_RES_INDIRECT = 4'b0011,
    OP_PROC_CREATE = 4'b0100,
    OP_PROC_REMOVE = 4'b0101,
    OP_LITERAL = 4'b0110,
    OP_POST_IRQ = 4'b0111,
    OP_FAULT_CHECK = 4'b1000,
    OP_FLAG_CHECK = 4'b1001,
    OP_GET_VSPACE = 4'b1010,
    OP_SUP_CALL = 4'b1011,
    OP_SUP_RETURN = 4'b1100,
    OP_LOAD_AVR = 4'b1101,
    OP_SET_ATTR = 4'b1110
  } op_e;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WAIT_AU = 3'b001,
    S_UPD = 3'b010,
    S_PURGE = 3'b011,
    S_LOAD = 3'b100
  } state_e;
endpackage : psv_pkg

// *** sim/au_model.sv ***
// arithmetic unit stand-in that answers the operator unit
// assumes the bench raises go and holds it until the operator ends
`timescale 1ns/1ps
module au_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request from the bench
  input wire logic go,
  input wire logic [3:0] lat,
  input wire logic [31:0] data_in,
  // answer
  output logic arith_done,
  output logic [31:0] arith_result
);
  logic [3:0] cnt_r; // cycles since go rose
  // count while go is held; done is a level once lat is reached
  always_ff @(posedge clk) begin
    if (sys_rst || !go) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != lat) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign arith_done = go && (cnt_r == lat);
  // outside done the result is inverted so a stale read cannot match
  assign arith_result = arith_done ? data_in + 32'h1 : ~(data_in + 32'h1);
endmodule : au_model

// *** sim/testbench.sv ***
// self-checking bench for the supervisor operator unit
// assumes the unit and au_model are compiled before it
`timescale 1ns/1ps
module testbench;
  // bench-driven inputs, plus some unit and model outputs of the same widths
  logic clk, sys_rst, reg_wr, reg_rd, op_valid, ref_is_l1, desc_is_data, au_go;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, op_ref, value_stack_top, arith_result, reg_rdata_r;
  logic [3:0] op_code, au_lat;
  logic [1:0] op_len, ns_tag_r;
  logic [15:0] cd_parent_ccf, ccf_old_r, ccf_r;
  logic [64:0] fault_set;
  logic [16:0] flag_pin;
  // unit and model outputs
  logic arith_done, op_done_r, vs_push_r, vs_alloc_r, vs_pop_r, ns_push_r, rs_push_r;
  logic slice_new_r, slice_del_r, cd_pop_r, ccf_wr_r, irq_r, fault_r, handler_r, attr_wr_r;
  logic priv_r, sense_r, upd_r, purge_r, load_base_r, load_proc_r, pcr_load_r;
  logic [31:0] st_data_r, rs_data_r, attr_val_r, avr_r, pcr_val_r;
  logic [7:0] irq_chan_r, level_r;
  logic [6:0] handler_num_r;
  logic [2:0] upd_idx_r;
  // bookkeeping
  int failures, n_compared, ncyc, nupd, npur;
  logic [15:0] seen;
  wire [15:0] pulses = {fault_r, vs_push_r, ns_push_r, rs_push_r, vs_pop_r, irq_r,
    handler_r, attr_wr_r, slice_new_r, slice_del_r, cd_pop_r, ccf_wr_r, vs_alloc_r,
    pcr_load_r, load_base_r, load_proc_r};

  process_supervisor_operators process_supervisor_operators_inst (.clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_r, .op_valid, .op_code, .op_ref,
    .op_len, .ref_is_l1, .desc_is_data, .op_done_r, .value_stack_top, .cd_parent_ccf,
    .arith_done, .arith_result, .fault_set, .flag_pin, .vs_push_r, .vs_alloc_r, .vs_pop_r,
    .ns_push_r, .ns_tag_r, .st_data_r, .rs_push_r, .rs_data_r, .slice_new_r, .slice_del_r,
    .cd_pop_r, .ccf_wr_r, .ccf_old_r, .ccf_r, .irq_r, .irq_chan_r, .fault_r, .handler_r,
    .handler_num_r, .attr_wr_r, .attr_val_r, .avr_r, .level_r, .priv_r, .sense_r, .upd_r,
    .upd_idx_r, .purge_r, .load_base_r, .load_proc_r, .pcr_load_r, .pcr_val_r);
  au_model au_model_inst (.clk, .sys_rst, .go(au_go), .lat(au_lat),
    .data_in(value_stack_top), .arith_done, .arith_result);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_r;
  endtask : rd

  // issue an operator and gather every pulse until done or fault
  task automatic issue(input logic [3:0] c, input logic [31:0] r);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_ref <= r;
    @(posedge clk);
    op_valid <= 1'b0;
    seen = 16'h0;
    nupd = 0;
    npur = 0;
    for (ncyc = 1; ncyc < 40; ncyc++) begin
      #1 seen |= pulses;
      nupd += int'(upd_r);
      npur += int'(purge_r);
      if (op_done_r === 1'b1 || fault_r === 1'b1) break;
      @(posedge clk);
    end
  endtask : issue

  // reset values of the status, variant and level registers
  task automatic t_reset();
    logic [31:0] v;
    rd(8'h00, v);
    chk(v, 32'h2);
    rd(8'h1c, v);
    chk(v, 32'h0);
    rd(8'h20, v);
    chk(v, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // privileged operators refused in normal mode
  task automatic t_refuse();
    logic [31:0] v;
    ref_is_l1 <= 1'b1;
    issue(psv_pkg::OP_RES_DIRECT, 32'h10);
    chk(seen, 16'h8000);
    issue(psv_pkg::OP_PROC_CREATE, 32'h0);
    chk(seen, 16'h8000);
    issue(psv_pkg::OP_SUP_RETURN, 32'h0);
    chk(seen, 16'h8000);
    rd(8'h2c, v);
    chk(v, 32'h1);
    $display("test refuse done");
  endtask : t_refuse

  // check the common steps of entry or return
  task automatic chk_seq(input logic [31:0] pc, input logic pv);
    chk(ncyc, 32'd7);
    chk(nupd, 32'd5);
    chk(upd_idx_r, 32'h4);
    chk(npur, 32'd1);
    chk(pcr_val_r, pc);
    chk(priv_r, pv);
    chk(sense_r, !pv);
  endtask : chk_seq

  // unmasked external fault enters the supervisor
  task automatic t_entry();
    logic [31:0] v;
    wr(8'h0c, 32'h1);
    issue(psv_pkg::OP_FAULT_CHECK, 32'h0);
    chk(seen, 16'h7006);
    chk(st_data_r, 32'd64);
    chk(ns_tag_r, 2'h3);
    chk(rs_data_r, 32'h0);
    chk_seq(32'h100, 1'b1);
    rd(8'h2c, v);
    chk(v, 32'h0);
    $display("test entry done");
  endtask : t_entry

  // resource passing, process create and remove in privileged mode
  task automatic t_priv();
    issue(psv_pkg::OP_RES_DIRECT, 32'h1234);
    chk(seen, 16'h1000);
    chk(rs_data_r, 32'h80001234);
    issue(psv_pkg::OP_RES_INDIRECT, 32'h80000055);
    chk(rs_data_r, 32'h00000055);
    ref_is_l1 <= 1'b0;
    issue(psv_pkg::OP_RES_DIRECT, 32'h1);
    chk(seen, 16'h8000);
    issue(psv_pkg::OP_PROC_CREATE, 32'h0);
    chk(seen, 16'h0080);
    chk(level_r, 8'h1);
    issue(psv_pkg::OP_PROC_REMOVE, 32'h0);
    chk(seen, 16'h0040);
    chk(level_r, 8'h0);
    issue(psv_pkg::OP_SUP_RETURN, 32'h0);
    chk(seen, 16'h0005);
    chk_seq(32'h200, 1'b0);
    $display("test privileged done");
  endtask : t_priv

  // process-masked faults go to the handler, lowest first
  // the illegal-operator fault left pending stays masked off here
  task automatic t_handler();
    wr(8'h0c, 32'h0);
    wr(8'h10, 32'h28);
    @(posedge clk);
    fault_set <= 65'h28;
    @(posedge clk);
    fault_set <= '0;
    issue(psv_pkg::OP_FAULT_CHECK, 32'h0);
    chk(seen, 16'h6200);
    chk(handler_num_r, 7'd3);
    chk(st_data_r, 32'd3);
    issue(psv_pkg::OP_FAULT_CHECK, 32'h0);
    chk(handler_num_r, 7'd5);
    issue(psv_pkg::OP_FAULT_CHECK, 32'h0);
    chk(seen, 16'h0);
    $display("test handler done");
  endtask : t_handler

  // a set system flag enters the supervisor with its number
  task automatic t_flag();
    flag_pin <= 17'h4;
    repeat (3) @(posedge clk);
    issue(psv_pkg::OP_FLAG_CHECK, 32'h0);
    chk(seen, 16'h7006);
    chk(st_data_r, 32'd2);
    chk_seq(32'h100, 1'b1);
    flag_pin <= '0;
    issue(psv_pkg::OP_SUP_RETURN, 32'h0);
    $display("test flag done");
  endtask : t_flag

  // one-cycle operators
  task automatic t_simple();
    logic [31:0] v;
    issue(psv_pkg::OP_LITERAL, 32'h5);
    chk(seen, 16'h6000);
    chk(st_data_r, 32'h5);
    chk(ns_tag_r, 2'h2);
    value_stack_top <= 32'h9;
    issue(psv_pkg::OP_POST_IRQ, 32'h0);
    chk(seen, 16'h0c00);
    chk(irq_chan_r, 8'h9);
    value_stack_top <= 32'hcafe0001;
    issue(psv_pkg::OP_LOAD_AVR, 32'h0);
    chk(seen, 16'h0800);
    rd(8'h1c, v);
    chk(v, 32'hcafe0001);
    cd_parent_ccf <= 16'h00a5;
    issue(psv_pkg::OP_CO_EXIT, 32'h0);
    chk(seen, 16'h0030);
    chk({ccf_old_r, ccf_r}, 32'h000000a5);
    issue(psv_pkg::OP_GET_VSPACE, 32'h10);
    chk(seen, 16'h8000);
    desc_is_data <= 1'b1;
    issue(psv_pkg::OP_GET_VSPACE, 32'h10);
    chk(seen, 16'h2008);
    chk(st_data_r, 32'h10);
    $display("test simple done");
  endtask : t_simple

  // operators that wait for the arithmetic unit
  task automatic t_arith();
    value_stack_top <= 32'h7;
    au_lat <= 4'h6;
    au_go <= 1'b1;
    issue(psv_pkg::OP_SET_ATTR, 32'h0);
    chk(seen, 16'h0100);
    chk(attr_val_r, 32'h8);
    chk(ncyc, 32'd6);
    au_go <= 1'b0;
    @(posedge clk);
    au_go <= 1'b1;
    issue(psv_pkg::OP_SUP_CALL, 32'h11);
    chk(ncyc, 32'd12);
    chk(st_data_r, 32'h11);
    au_go <= 1'b0;
    issue(psv_pkg::OP_SUP_RETURN, 32'h0);
    chk(priv_r, 1'b0);
    $display("test arith done");
  endtask : t_arith

  // print counts and verdict, then stop
  task automatic finish_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // cut a hang short
  initial begin
    #(25 * 5000);
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    {sys_rst, reg_wr, reg_rd, op_valid, ref_is_l1, desc_is_data, au_go} = 7'h40;
    {reg_addr, reg_wdata, op_ref, value_stack_top, op_code, au_lat, op_len} = '0;
    {cd_parent_ccf, fault_set, flag_pin} = '0;
    failures = 0;
    n_compared = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_refuse();
    t_entry();
    t_priv();
    t_handler();
    t_flag();
    t_simple();
    t_arith();
    finish_test();
  end
endmodule : testbench
